// ---- hw/adc_seq_pkg.sv ----
package adc_seq_pkg;

    // ****************************************************
    // register byte addresses
    // ****************************************************
    localparam logic [7:0] ADDR_CHANNEL = 8'h00; // on, start, channel
    localparam logic [7:0] ADDR_ACQCLK  = 8'h04; // align, acq, clock
    localparam logic [7:0] ADDR_RES_HI  = 8'h08; // result high byte
    localparam logic [7:0] ADDR_RES_LO  = 8'h0C; // result low byte
    localparam logic [7:0] ADDR_FLAGS   = 8'h10; // flag, irq enable

    // ****************************************************
    // field positions
    // ****************************************************
    localparam int BIT_ON      = 0;
    localparam int BIT_GO      = 1;
    localparam int BIT_CHS_LO  = 2;
    localparam int BIT_ALIGN   = 7;
    localparam int BIT_ACQ_LO  = 3;
    localparam int BIT_FLAG    = 0;
    localparam int BIT_IRQ_EN  = 1;

    // ****************************************************
    // reset values and cycle counts
    // ****************************************************
    localparam logic [7:0] RST_ACQCLK = 8'h00;
    localparam logic [3:0] RST_CHS    = 4'h0;
    localparam int CONV_PERIODS = 11; // bit periods per conversion
    localparam int WAIT_PERIODS = 3;  // quiet time after conversion
    localparam int CLK_MHZ      = 20;
    localparam int INSTR_NS     = 200; // one instruction cycle
    localparam int INSTR_CYC    = INSTR_NS * CLK_MHZ / 1000;
    localparam int RC_DIV       = 80;  // internal RC period in clk

    typedef enum logic [1:0] {
        ST_SAMPLE,
        ST_ACQ,
        ST_CONV,
        ST_WAIT
    } seq_state_t;

    // acquisition code to bit periods
    function automatic logic [4:0] acq_periods(input logic [2:0] c);
        case (c)
            3'h7:    acq_periods = 5'h14;
            3'h6:    acq_periods = 5'h10;
            3'h5:    acq_periods = 5'h0C;
            3'h4:    acq_periods = 5'h08;
            3'h3:    acq_periods = 5'h06;
            3'h2:    acq_periods = 5'h04;
            3'h1:    acq_periods = 5'h02;
            default: acq_periods = 5'h00;
        endcase
    endfunction : acq_periods

endpackage : adc_seq_pkg

// ---- hw/tad_if.sv ----
// bit-period tick between the clock generator and the sequencer
interface tad_if;
    logic       run;     // sequencer wants ticks
    logic [2:0] clk_sel; // clock select code
    logic       tick;    // one bit period elapsed
    logic       is_rc;   // RC source selected
    modport gen (input run, input clk_sel, output tick, output is_rc);
    modport seq (output run, output clk_sel, input tick, input is_rc);
endinterface : tad_if

// ---- hw/tad_gen.sv ----
module tad_gen
    import adc_seq_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    tad_if.gen        t
);
    // ****************************************************
    // bit period generator
    // ****************************************************
    logic [6:0] cnt_q;   // divider count
    logic [6:0] limit;   // terminal count for current code
    logic [2:0] dly_q;   // instruction cycle delay for RC

    // decode divider; any x11 code is the RC clock
    always_comb
    begin
        unique case (t.clk_sel)
            3'h0: limit = 7'h01; // osc/2
            3'h4: limit = 7'h03;
            3'h1: limit = 7'h07;
            3'h5: limit = 7'h0F;
            3'h2: limit = 7'h1F;
            3'h6: limit = 7'h3F;
            default: limit = 7'(RC_DIV - 1);
        endcase
    end

    assign t.is_rc = (t.clk_sel[1:0] == 2'b11);

    // delay count restarts whenever the sequencer goes idle
    always_ff @(posedge clk)
    begin
        if (reset || !t.run)
            dly_q <= '0;
        else if (t.is_rc && dly_q != 3'(INSTR_CYC))
            dly_q <= dly_q + 3'h1;
    end

    // divider counts only once the start delay is over
    always_ff @(posedge clk)
    begin
        if (reset || !t.run)
            cnt_q <= '0;
        else if (t.is_rc && dly_q != 3'(INSTR_CYC))
            cnt_q <= '0;
        else if (cnt_q >= limit)
            cnt_q <= '0;
        else
            cnt_q <= cnt_q + 7'h01;
    end

    assign t.tick = t.run && (cnt_q >= limit)
                    && !(t.is_rc && dly_q != 3'(INSTR_CYC));

    initial assert (INSTR_CYC >= 1 && INSTR_CYC < 8);
endmodule : tad_gen

// ---- hw/adc_seq_ctrl.sv ----
module adc_seq_ctrl
    import adc_seq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // converter front end
    output logic             sample_connect,
    output logic             conv_active,
    output logic      [3:0]  channel_sel,
    output logic      [9:0]  sar_trial,
    input  wire logic        comp_in,
    output logic             conv_complete_irq
);
    import adc_seq_pkg::*;

    // ****************************************************
    // registers and bus state
    // ****************************************************
    tad_if t ();

    seq_state_t  state_q;           // sequencer phase
    logic        on_q;              // converter_on
    logic        go_q;              // start/done flag
    logic [3:0]  chs_q;             // channel select
    logic        align_q;           // result_align_sel
    logic [2:0]  acq_q;             // acq_time_sel
    logic [2:0]  clk_q;             // conv_clk_sel
    logic        flag_q;            // conv_complete_flag
    logic        ien_q;             // conv_complete_irq_en
    logic [9:0]  res_q;             // result, never reset
    logic [9:0]  sar_q;             // approximation register
    logic [3:0]  bit_q;             // bit index within conversion
    logic [4:0]  per_q;             // period counter
    logic        wr_q;              // pending write phase
    logic [7:0]  wa_q;              // latched write address
    logic        done;              // conversion finished this cycle
    logic        start_wr;          // software sets go
    logic        stop_wr;           // software clears go
    logic        wr_en;             // data phase write strobe
    logic        wr_chan;           // data phase write to channel reg
    logic        wr_acq;            // data phase write to acq/clock reg
    logic        wr_flg;            // data phase write to flag reg
    logic        rd_req;            // read address phase
    logic [31:0] rd_val;            // read mux

    tad_gen u_tad (
        .clk   (clk),
        .reset (reset),
        .t     (t.gen)
    );

    // ****************************************************
    // shared decode helpers
    // ****************************************************
    // a transfer is taken when selected, ready and NONSEQ or SEQ; the
    // read and the write capture must agree, so both use this
    function automatic logic bus_take(input logic       sel,
                                      input logic       rdy,
                                      input logic [1:0] tr);
        bus_take = sel && rdy && tr[1];
    endfunction : bus_take

    // write hit on one register during the data phase
    function automatic logic wr_hit(input logic       en,
                                    input logic [7:0] a,
                                    input logic [7:0] reg_a);
        wr_hit = en && (a == reg_a);
    endfunction : wr_hit

    // ****************************************************
    // bus decode
    // ****************************************************
    // single-word, zero-wait slave: always ready, always OKAY;
    // with no wait states no read data path needs holding
    assign wr_en   = wr_q;
    assign wr_chan = wr_hit(wr_en, wa_q, ADDR_CHANNEL);
    assign wr_acq  = wr_hit(wr_en, wa_q, ADDR_ACQCLK);
    assign wr_flg  = wr_hit(wr_en, wa_q, ADDR_FLAGS);
    assign rd_req  = bus_take(hsel, hready, htrans) && !hwrite;

    // write address phase captured for the next data phase
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wr_q <= 1'b0;
            wa_q <= 8'h00;
        end
        else
        begin
            wr_q <= bus_take(hsel, hready, htrans) && hwrite;
            wa_q <= haddr;
        end
    end

    // start needs the converter already on: setting go in the same
    // write that turns the converter on is refused on purpose
    assign start_wr = wr_chan && on_q && hwdata[BIT_GO] && !go_q;
    // clearing go while busy is the software abort
    assign stop_wr  = wr_chan && !hwdata[BIT_GO] && go_q;

    // reads have no side effects, so polling the flags is safe
    // even on the edge at which a conversion completes
    // read data mux; unmapped addresses read zero
    always_comb
    begin
        unique case (haddr)
            ADDR_CHANNEL: rd_val = {26'h0, chs_q, go_q, on_q};
            // bit 6 is unimplemented
            ADDR_ACQCLK:  rd_val = {24'h0, align_q, 1'b0, acq_q, clk_q};
            ADDR_RES_HI:  rd_val = align_q ? {30'h0, res_q[9:8]}
                                           : {24'h0, res_q[9:2]};
            ADDR_RES_LO:  rd_val = align_q ? {24'h0, res_q[7:0]}
                                           : {24'h0, res_q[1:0], 6'h0};
            ADDR_FLAGS:   rd_val = {30'h0, ien_q, flag_q};
            default:      rd_val = 32'h0;
        endcase
    end // result pair justification

    // read data registered into the data phase
    always_ff @(posedge clk)
    begin
        if (reset)
            hrdata <= 32'h0;
        else if (rd_req)
            hrdata <= rd_val;
    end

    // bus response is constant
    // tied off through flops so every output stays registered
    always_ff @(posedge clk)
    begin
        hreadyout <= 1'b1;
        hresp     <= 1'b0;
    end

    // ****************************************************
    // control registers
    // ****************************************************
    // setup registers; reset turns the converter off
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            on_q  <= 1'b0;
            chs_q <= RST_CHS;
        end
        else if (wr_chan)
        begin
            on_q  <= hwdata[BIT_ON];            // off also aborts
            chs_q <= hwdata[BIT_CHS_LO +: 4];   // takes effect at once
        end
    end

    // acquisition and clock setup; bit 6 is simply not stored
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            align_q <= RST_ACQCLK[BIT_ALIGN];
            acq_q   <= RST_ACQCLK[BIT_ACQ_LO +: 3];
            clk_q   <= RST_ACQCLK[2:0];
        end
        else if (wr_acq)
        begin
            // codes are not guarded during a conversion: a new clock
            // changes the terminal count of the bit period in progress
            align_q <= hwdata[BIT_ALIGN];
            acq_q   <= hwdata[BIT_ACQ_LO +: 3];
            clk_q   <= hwdata[2:0];
        end
    end

    // interrupt enable
    always_ff @(posedge clk)
    begin
        if (reset)
            ien_q <= 1'b0;
        else if (wr_flg)
            ien_q <= hwdata[BIT_IRQ_EN];
    end

    // start/done flag: cleared by completion or abort
    // start is only taken while go is low; if it meets done in one cycle, done wins
    always_ff @(posedge clk)
    begin
        if (reset)
            go_q <= 1'b0;
        else if (done)
            go_q <= 1'b0;
        else if (start_wr)
            go_q <= 1'b1; // stays high through acq and conv
        else if (stop_wr || !on_q)
            go_q <= 1'b0;
    end

    // completion flag: set wins over a software clear
    always_ff @(posedge clk)
    begin
        if (reset)
            flag_q <= 1'b0;
        else if (done)
            flag_q <= 1'b1;
        else if (wr_flg && !hwdata[BIT_FLAG])
            flag_q <= 1'b0; // only software or reset clears it
    end

    // ****************************************************
    // sequencer
    // ****************************************************
    assign t.clk_sel = clk_q;
    assign t.run     = state_q != ST_SAMPLE;
    assign done      = state_q == ST_CONV && t.tick
                       && bit_q == 4'(CONV_PERIODS - 1);

    // phase machine; with the RC source ticks still come from clk
    always_ff @(posedge clk)
    begin
        if (reset || !on_q)
        begin
            state_q <= ST_SAMPLE; // abort
            per_q   <= '0;
        end
        else
        begin
            unique case (state_q)
                // follow the input until go is seen
                ST_SAMPLE:
                    if (go_q && acq_q == 3'h0)
                        state_q <= ST_CONV;
                    else if (go_q)
                    begin
                        state_q <= ST_ACQ;
                        per_q   <= acq_periods(acq_q);
                    end
                ST_ACQ:
                    // an abort here still owes the quiet time
                    if (!go_q)
                    begin
                        state_q <= ST_WAIT;
                        per_q   <= 5'(WAIT_PERIODS);
                    end
                    else if (t.tick && per_q == 5'h01)
                        state_q <= ST_CONV;
                    else if (t.tick)
                        per_q <= per_q - 5'h01;
                // eleven ticks, or cut short by clearing go
                ST_CONV:
                    if (done || !go_q)
                    begin
                        state_q <= ST_WAIT;
                        per_q   <= 5'(WAIT_PERIODS);
                    end
                // hold off for the quiet periods before sampling
                ST_WAIT:
                    if (t.tick && per_q <= 5'h01)
                        state_q <= ST_SAMPLE;
                    else if (t.tick)
                        per_q <= per_q - 5'h01;
            endcase
        end
    end // RC ticks are clk divided by RC_DIV, so they need the core clock

    // successive approximation over eleven periods
    always_ff @(posedge clk)
    begin
        if (reset || state_q != ST_CONV)
        begin
            bit_q <= '0;
            sar_q <= 10'h200;
        end
        else if (t.tick)
        begin
            // tick 0 lets the held sample settle; ticks 1 to 10
            // judge bits 9 down to 0
            bit_q <= bit_q + 4'h1;
            if (bit_q != 4'h0 && bit_q <= 4'hA)
            begin
                if (!comp_in)
                    sar_q[4'hA - bit_q] <= 1'b0;
                if (bit_q != 4'hA)
                    sar_q[4'h9 - bit_q] <= 1'b1;
            end
        end
    end

    // result only written on completion, never by reset
    always_ff @(posedge clk)
    begin
        if (done)
            // bit 0 is judged on the completing edge itself
            res_q <= {sar_q[9:1], comp_in ? sar_q[0] : 1'b0};
    end

    // ****************************************************
    // front end outputs
    // ****************************************************
    // trial code comes straight from the approximation register, so
    // the comparator answer is back before the next bit period ends
    assign sar_trial = sar_q;

    // sampling switch and conversion marker
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sample_connect <= 1'b0;
            conv_active    <= 1'b0;
        end
        else
        begin
            // hold capacitor released during conversion
            sample_connect <= on_q && state_q != ST_CONV
                              && state_q != ST_WAIT;
            conv_active    <= state_q == ST_CONV;
        end
    end

    // channel select copy for the input multiplexer
    always_ff @(posedge clk)
    begin
        if (reset)
            channel_sel <= RST_CHS;
        else
            channel_sel <= chs_q;
    end

    // interrupt line is a level: flag and enable together
    always_ff @(posedge clk)
    begin
        if (reset)
            conv_complete_irq <= 1'b0;
        else
            conv_complete_irq <= flag_q && ien_q;
    end

endmodule : adc_seq_ctrl

// ---- sim/adc_seq_ctrl_props.sv ----
// ****************************************************
// bus and sequencer checks
// ****************************************************
module adc_seq_ctrl_props (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        sample_connect,
    input wire logic        conv_active,
    input wire logic        conv_complete_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);

    logic rd_req; // read address phase taken this edge
    assign rd_req = hsel && hready && htrans[1] && !hwrite;

    // slave never stalls and never errors
    property p_zero_wait;
        hreadyout && !hresp;
    endproperty
    a_zero_wait: assert property (p_zero_wait)
        else $error("bus stalled or errored");
    // unmapped reads give zero
    property p_unmapped;
        rd_req && haddr > 8'h10 |=> hrdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_bit6;
        rd_req && haddr == 8'h04 |=> (hrdata & 32'hFFFFFF40) == 32'h0;
    endproperty
    a_bit6: assert property (p_bit6)
        else $error("unused control bits read back set");
    // the input pin is cut off for the whole conversion
    property p_hold_cut;
        conv_active |-> !sample_connect;
    endproperty
    a_hold_cut: assert property (p_hold_cut)
        else $error("sampling during conversion");
    // fastest bit period is two clocks, so eleven periods exceed eight
    property p_conv_min;
        $rose(conv_active) |-> conv_active[*8];
    endproperty
    a_conv_min: assert property (p_conv_min)
        else $error("conversion too short");
    property p_conv_end;
        $rose(conv_active) |-> ##[1:1000] !conv_active;
    endproperty
    a_conv_end: assert property (p_conv_end)
        else $error("conversion never ends");
    property p_wait;
        $fell(conv_active) |-> !sample_connect[*6];
    endproperty
    a_wait: assert property (p_wait)
        else $error("acquisition resumed too early");
    property p_resume;
        $fell(conv_active) |-> ##[6:400] sample_connect;
    endproperty
    a_resume: assert property (p_resume)
        else $error("sampling did not resume");

    c_conv: cover property ($rose(conv_active));
    c_irq: cover property ($rose(conv_complete_irq));
    c_unmapped: cover property (rd_req && haddr > 8'h10);
endmodule : adc_seq_ctrl_props

bind adc_seq_ctrl adc_seq_ctrl_props u_props (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sample_connect(sample_connect), .conv_active(conv_active),
    .conv_complete_irq(conv_complete_irq)
);

// ---- sim/tb_adc_sequencer_control.sv ----
module tb_adc_sequencer_control
    import adc_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************
    // signals and expectation queue
    // ****************************************************
    typedef struct {
        logic [7:0]  a; // register read
        logic [31:0] e; // value expected
        bit          c; // compare or just poll
    } note_t;
    logic        clk = 1'b0, reset = 1'b1, hsel = 1'b0;
    logic        hwrite = 1'b0, comp_in = 1'b0, rd_ph = 1'b0;
    logic        hreadyout, hresp, sample_connect, conv_active, irq;
    wire logic   hready;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [3:0]  channel_sel;
    logic [7:0]  haddr = 8'h00;
    logic [9:0]  sar_trial, ain = 10'h000;
    logic [31:0] hwdata = 32'h0, hrdata, last, exp_hi, exp_lo;
    int          bad_count, tests_run;
    note_t       exp_q[$];
    note_t       n;

    assign hready = hreadyout; // single slave drives the bus ready
    always #25 clk = ~clk;

    adc_seq_ctrl DUT (
        .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .sample_connect(sample_connect), .conv_active(conv_active),
        .channel_sel(channel_sel), .sar_trial(sar_trial),
        .comp_in(comp_in), .conv_complete_irq(irq)
    );

    // comparator: analog level at or above the trial code
    always @(posedge clk) comp_in <= (ain >= sar_trial);

    // ****************************************************
    // compare, bus and sequence tasks
    // ****************************************************
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, g);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value hrdata at %h expected %h seen %h", a, e, g);
        end
    endtask : chk_rd

    task automatic chk_pin(input string nm, input logic e, g);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_pin

    // one single transfer; read data kept in last
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [7:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do @(posedge clk); while (hready !== 1'b1);
        last = hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(a, 1'b1, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input bit c);
        exp_q.push_back('{a, e, c});
        xfer(a, 1'b0, 8'h00);
    endtask : rd

    // k picks acquisition and clock code alike; k[0] picks alignment
    task automatic convert(input logic [2:0] k);
        ain = 10'($urandom);
        exp_hi = k[0] ? {30'h0, ain[9:8]} : {24'h0, ain[9:2]};
        exp_lo = k[0] ? {24'h0, ain[7:0]} : {24'h0, ain[1:0], 6'h0};
        wr(ADDR_ACQCLK, {k[0], 1'b0, k, k});
        wr(ADDR_CHANNEL, {3'h0, k, 2'b01});
        if (k == 3'h0)
            repeat (48) @(posedge clk);
        wr(ADDR_CHANNEL, {3'h0, k, 2'b11});
        repeat (3) @(posedge clk);
        chk_pin("conv_active", k == 3'h0, conv_active);
        chk_pin("sample_connect", k != 3'h0, sample_connect);
        rd(ADDR_FLAGS, {30'h0, 1'b1, k != 3'h0}, 1);
        rd(ADDR_CHANNEL, {27'h0, k, 2'b11}, 1);
        // poll until the start flag drops; bounded against a hang
        for (int t = 0; t < 3000 && last[1]; t++)
            rd(ADDR_CHANNEL, 32'h0, 0);
        chk_pin("done", 1'b0, last[1]);
        rd(ADDR_RES_HI, exp_hi, 1);
        rd(ADDR_RES_LO, exp_lo, 1);
        rd(ADDR_FLAGS, 32'h3, 1);
        chk_pin("irq", 1'b1, irq);
        repeat (260) @(posedge clk);
        chk_pin("sample_connect", 1'b1, sample_connect);
        chk_pin("channel_sel", 1'b1, channel_sel == {1'b0, k});
    endtask : convert

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    // ****************************************************
    // read monitor and main sequence
    // ****************************************************
    // each read data phase takes the oldest note
    always @(posedge clk)
    begin
        if (rd_ph)
        begin
            n = exp_q.pop_front();
            if (n.c)
                chk_rd(n.a, n.e, hrdata);
        end
        rd_ph <= hsel && hready && htrans[1] && !hwrite;
    end

    initial
    begin
        void'($urandom(32'h704E61D8));
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        rd(ADDR_ACQCLK, 32'h0, 1);
        rd(ADDR_CHANNEL, 32'h0, 1);
        wr(8'h14, 8'hFF);
        rd(8'h14, 32'h0, 1);
        wr(ADDR_ACQCLK, 8'hFF);
        rd(ADDR_ACQCLK, 32'hBF, 1);
        wr(ADDR_FLAGS, 8'h02);
        // codes 3 and 7 pick the RC clock, divided down from clk
        for (int i = 0; i < 8; i++)
            convert(3'(i));
        // abort mid-conversion: the old result must survive
        wr(ADDR_ACQCLK, 8'h86); // osc/64 at 20 MHz
        ain = ~ain;
        wr(ADDR_CHANNEL, 8'h03);
        repeat (40) @(posedge clk);
        wr(ADDR_CHANNEL, 8'h01);
        repeat (400) @(posedge clk);
        rd(ADDR_RES_HI, exp_hi, 1);
        rd(ADDR_RES_LO, exp_lo, 1);
        // reset in mid-conversion
        wr(ADDR_CHANNEL, 8'h03);
        repeat (20) @(posedge clk);
        reset <= 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        chk_pin("conv_active", 1'b0, conv_active);
        rd(ADDR_CHANNEL, 32'h0, 1);
        rd(ADDR_ACQCLK, 32'h0, 1);
        rd(ADDR_FLAGS, 32'h0, 1);
        repeat (2) @(posedge clk);
        report_and_stop();
    end

    // watchdog: the sequence needs well under this many cycles
    initial
    begin
        #(50 * 60000);
        bad_count++;
        report_and_stop();
    end
endmodule : tb_adc_sequencer_control
